// ===== rtl/reb_pkg.sv
/*
  Shared constants for the repeater expansion bus: clock ratios, byte
  layout, buffer depth, synchroniser bit positions and bus states.
  Assumes a 40 MHz system clock at every end.
*/
package reb_pkg;
  localparam int SYS_CLK_MHZ = 40;
  localparam int BUS_DATA_CLOCK_MHZ = 10;
  localparam int BUS_DATA_CLOCK_DIV = SYS_CLK_MHZ / BUS_DATA_CLOCK_MHZ;
  localparam int BUS_DATA_CLOCK_HIGH_FROM = BUS_DATA_CLOCK_DIV / 2;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int STAT_W = 16;
  localparam int NDEV = 3;
  // synchroniser lanes
  localparam int IN_SER = 0;
  localparam int IN_JAM = 1;
  localparam int IN_ACK = 2;
  localparam int IN_COL = 3;
  localparam int IN_CLK = 4;
  localparam int IN_MAC = 5;
  localparam int IN_STRAP = 6;
  localparam int IN_W = 7;
  localparam logic [IN_W-1:0] IN_IDLE = 7'h3c;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SEND = 4'h2,
    ST_RECV = 4'h4,
    ST_JAM = 4'h8
  } reb_state_e;
endpackage

// ===== rtl/reb_if.sv
/*
  Expansion bus wiring between up to NDEV repeater ends and one arbiter.
  Shared lines are resolved here from each end's output and enable;
  an undriven line reads low.
*/
`timescale 1ns/10ps
interface reb_if #(parameter int NDEV = reb_pkg::NDEV);
  logic bus_serial_line;
  logic jam_line;
  logic bus_data_clock;
  logic ack_n;
  logic col_n;
  logic req_n [NDEV];
  logic bus_serial_line_o [NDEV];
  logic bus_serial_line_oe [NDEV];
  logic jam_o [NDEV];
  logic jam_oe [NDEV];
  logic bus_data_clock_o [NDEV];
  logic bus_data_clock_oe [NDEV];

  // wired-or of every enabled driver
  always_comb begin
    bus_serial_line = 1'b0;
    jam_line = 1'b0;
    bus_data_clock = 1'b0;
    for (int i = 0; i < NDEV; i++) begin
      bus_serial_line = bus_serial_line | (bus_serial_line_o[i] & bus_serial_line_oe[i]);
      jam_line = jam_line | (jam_o[i] & jam_oe[i]);
      bus_data_clock = bus_data_clock | (bus_data_clock_o[i] & bus_data_clock_oe[i]);
    end
  end

  modport dev (
    input bus_serial_line, jam_line, bus_data_clock, ack_n, col_n,
    output req_n, bus_serial_line_o, bus_serial_line_oe, jam_o, jam_oe,
    output bus_data_clock_o, bus_data_clock_oe
  );
  modport arb (
    input req_n,
    output ack_n, col_n
  );
endinterface

// ===== rtl/reb_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module reb_fifo #(
  parameter int WIDTH = reb_pkg::BYTE_W,
  parameter int DEPTH = reb_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("reb_fifo: DEPTH must be a power of two and at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] count;
    logic ready;
    logic valid;
  } reb_fifo_s;

  reb_fifo_s r;
  reb_fifo_s next_r;
  logic push;
  logic pop;

  assign in_ready = r.ready;
  assign out_valid = r.valid;
  assign out_data = r.mem[r.rd];

  always_comb begin
    next_r = r;
    push = in_valid & r.ready;
    pop = out_ready & r.valid;
    if (push) begin
      next_r.mem[r.wr] = in_data;
      next_r.wr = r.wr + 1'b1;
    end
    if (pop) begin
      next_r.rd = r.rd + 1'b1;
    end
    next_r.count = r.count + CW'(push) - CW'(pop);
    next_r.ready = next_r.count != FULL;
    next_r.valid = next_r.count != '0;
    if (rst) begin
      next_r.wr = '0;
      next_r.rd = '0;
      next_r.count = '0;
      next_r.ready = 1'b1;
      next_r.valid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end
endmodule

// ===== rtl/reb_device.sv
/*
  One repeater end of the expansion bus: requests the bus, sends buffered
  bytes or jam state when granted, follows the bus otherwise.
  Assumes the arbiter end on the same interface and one SYS_CLK shared by
  every end in synchronous mode.
*/
`timescale 1ns/10ps
module reb_device #(
  parameter int SLOT = 0,
  parameter int NDEV = reb_pkg::NDEV,
  parameter int FIFO_DEPTH = reb_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // straps and pins
  input wire logic BUS_MODE_STRAP,
  input wire logic MAC_ATTACH_SELECT_N,
  // local repeater state
  input wire logic TX_ACTIVE,
  input wire logic LOCAL_COLL,
  input wire logic LOCAL_MULTI,
  // bytes to send
  input wire logic TX_VALID,
  input wire logic [reb_pkg::BYTE_W-1:0] TX_DATA,
  output logic TX_READY,
  // bytes received
  output logic RX_VALID,
  output logic [reb_pkg::BYTE_W-1:0] RX_DATA,
  // status
  output logic ASYNC_MODE,
  output logic BUS_OWNER,
  output logic JAM_ACTIVE,
  output logic JAM_MULTI,
  output logic [reb_pkg::STAT_W-1:0] STAT_FRAMES,
  // bus
  reb_if.dev bus
);
  localparam int DW = $clog2(reb_pkg::BUS_DATA_CLOCK_DIV);
  localparam int BW = $clog2(reb_pkg::BYTE_W);
  localparam logic [DW-1:0] DIV_LAST = DW'(reb_pkg::BUS_DATA_CLOCK_DIV - 1);
  localparam logic [DW-1:0] DIV_HIGH = DW'(reb_pkg::BUS_DATA_CLOCK_HIGH_FROM);
  localparam logic [BW-1:0] BIT_LAST = BW'(reb_pkg::BYTE_W - 1);

  generate
    if (SLOT < 0 || SLOT >= NDEV || reb_pkg::BUS_DATA_CLOCK_DIV < 2) begin : g_bad
      $error("reb_device: SLOT out of range or clock ratio too small");
    end
  endgenerate

  typedef struct packed {
    logic [reb_pkg::IN_W-1:0] s1;
    logic [reb_pkg::IN_W-1:0] s2;
    logic [reb_pkg::IN_W-1:0] s3;
    logic [reb_pkg::IN_W-1:0] filt;
    logic clk_prev;
    logic async_mode;
    reb_pkg::reb_state_e state;
    logic [DW-1:0] div;
    logic [reb_pkg::BYTE_W-1:0] tx_sh;
    logic [BW:0] tx_left;
    logic [reb_pkg::BYTE_W-1:0] rx_sh;
    logic [BW-1:0] rx_cnt;
    logic rx_valid;
    logic [reb_pkg::BYTE_W-1:0] rx_data;
    logic ser_o;
    logic ser_oe;
    logic jam_o;
    logic jam_oe;
    logic req_n;
    logic clk_o;
    logic clk_oe;
    logic jam_active;
    logic jam_multi;
    logic [reb_pkg::STAT_W-1:0] stat;
    logic bus_owner;
  } reb_dev_s;

  reb_dev_s r;
  reb_dev_s next_r;
  logic [reb_pkg::IN_W-1:0] raw;
  logic [reb_pkg::IN_W-1:0] view;
  logic owner;
  logic listener;
  logic contention;
  logic tick;
  logic rx_tick;
  logic fifo_valid;
  logic fifo_ready;
  logic [reb_pkg::BYTE_W-1:0] fifo_data;

  reb_fifo #(.WIDTH(reb_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .in_valid(TX_VALID),
    .in_data(TX_DATA),
    .in_ready(TX_READY),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_ready)
  );

  assign raw = {BUS_MODE_STRAP, MAC_ATTACH_SELECT_N, bus.bus_data_clock, bus.col_n,
                bus.ack_n, bus.jam_line, bus.bus_serial_line};
  assign RX_VALID = r.rx_valid;
  assign RX_DATA = r.rx_data;
  assign ASYNC_MODE = r.async_mode;
  assign BUS_OWNER = r.bus_owner;
  assign JAM_ACTIVE = r.jam_active;
  assign JAM_MULTI = r.jam_multi;
  assign STAT_FRAMES = r.stat;
  assign bus.req_n[SLOT] = r.req_n;
  assign bus.bus_serial_line_o[SLOT] = r.ser_o;
  assign bus.bus_serial_line_oe[SLOT] = r.ser_oe;
  assign bus.jam_o[SLOT] = r.jam_o;
  assign bus.jam_oe[SLOT] = r.jam_oe;
  assign bus.bus_data_clock_o[SLOT] = r.clk_o;
  assign bus.bus_data_clock_oe[SLOT] = r.clk_oe;

  always_comb begin
    next_r = r;
    // three-stage synchroniser; a lane moves once stages two and three agree
    next_r.s1 = raw;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.filt = (r.s3 & ~(r.s2 ^ r.s3)) | (r.filt & (r.s2 ^ r.s3));
    // async mode reads filtered bus lines
    // sync mode reads lines on the shared clock
    view = r.async_mode ? r.filt : raw;
    view[reb_pkg::IN_MAC] = r.filt[reb_pkg::IN_MAC];
    contention = !view[reb_pkg::IN_COL];
    owner = !r.req_n && !view[reb_pkg::IN_ACK] && !contention;
    listener = r.req_n && !view[reb_pkg::IN_ACK] && !contention;
    next_r.req_n = !TX_ACTIVE;
    // 10 MHz data clock from divider
    next_r.div = (r.div == DIV_LAST) ? '0 : r.div + 1'b1;
    next_r.clk_o = next_r.div >= DIV_HIGH;
    // one NRZ bit per master clock in sync mode
    tick = r.async_mode ? (r.div == DIV_LAST) : 1'b1;
    next_r.clk_prev = view[reb_pkg::IN_CLK];
    // sync listener skips its entry cycle: the first bit is not on the line yet
    rx_tick = r.async_mode ? (view[reb_pkg::IN_CLK] && !r.clk_prev)
                           : (r.state == reb_pkg::ST_RECV);
    fifo_ready = owner && tick && r.tx_left == '0;
    next_r.rx_valid = 1'b0;
    next_r.jam_active = 1'b0;
    next_r.jam_multi = 1'b0;
    next_r.jam_o = 1'b0;
    next_r.ser_oe = owner;
    next_r.jam_oe = owner;
    // clock drive starts on a divider wrap, together with the first bit
    next_r.clk_oe = owner && r.async_mode && (r.clk_oe || tick);
    if (contention) begin
      next_r.state = reb_pkg::ST_JAM;
      next_r.jam_active = 1'b1;
      next_r.jam_multi = 1'b1;
      next_r.ser_o = 1'b0;
    end else if (owner) begin
      // sole remaining requester takes the lines back
      next_r.state = reb_pkg::ST_SEND;
      if (tick) begin
        if (r.tx_left != '0) begin
          next_r.ser_o = r.tx_sh[0];
          next_r.tx_sh = r.tx_sh >> 1;
          next_r.tx_left = r.tx_left - 1'b1;
        end else if (fifo_valid) begin
          next_r.ser_o = fifo_data[0];
          next_r.tx_sh = fifo_data >> 1;
          next_r.tx_left = (BW + 1)'(BIT_LAST);
        end else begin
          next_r.ser_o = 1'b0;
        end
      end
      if (LOCAL_COLL) begin
        next_r.jam_o = 1'b1;
        next_r.ser_o = !LOCAL_MULTI;
        next_r.jam_active = 1'b1;
        next_r.jam_multi = LOCAL_MULTI;
      end
    end else if (listener && view[reb_pkg::IN_JAM]) begin
      next_r.state = reb_pkg::ST_JAM;
      next_r.jam_active = 1'b1;
      next_r.jam_multi = !view[reb_pkg::IN_SER];
      next_r.ser_o = 1'b0;
    end else if (listener) begin
      next_r.state = reb_pkg::ST_RECV;
      next_r.ser_o = 1'b0;
    end else begin
      next_r.state = reb_pkg::ST_IDLE;
      next_r.ser_o = 1'b0;
    end
    if (!owner) begin
      next_r.tx_left = '0;
    end
    if (next_r.state == reb_pkg::ST_RECV) begin
      if (rx_tick) begin
        next_r.rx_sh = {view[reb_pkg::IN_SER], r.rx_sh[reb_pkg::BYTE_W-1:1]};
        next_r.rx_cnt = r.rx_cnt + 1'b1;
        if (r.rx_cnt == BIT_LAST) begin
          next_r.rx_valid = 1'b1;
          next_r.rx_data = next_r.rx_sh;
        end
      end
      // bus counted as one more port
      if (r.state != reb_pkg::ST_RECV && !view[reb_pkg::IN_MAC]) begin
        next_r.stat = r.stat + 1'b1;
      end
    end else begin
      next_r.rx_cnt = '0;
    end
    if (SYS_RST) begin
      // mode follows the strap only under reset
      // high selects asynchronous mode
      // filter keeps running here so the strap reaches the mode latch
      next_r.async_mode = r.filt[reb_pkg::IN_STRAP];
      next_r.clk_prev = 1'b0;
      next_r.state = reb_pkg::ST_IDLE;
      next_r.div = '0;
      next_r.tx_sh = '0;
      next_r.tx_left = '0;
      next_r.rx_sh = '0;
      next_r.rx_cnt = '0;
      next_r.rx_valid = 1'b0;
      next_r.rx_data = '0;
      next_r.ser_o = 1'b0;
      next_r.ser_oe = 1'b0;
      next_r.jam_o = 1'b0;
      next_r.jam_oe = 1'b0;
      next_r.req_n = 1'b1;
      next_r.clk_o = 1'b0;
      next_r.clk_oe = 1'b0;
      next_r.jam_active = 1'b0;
      next_r.jam_multi = 1'b0;
      next_r.stat = '0;
    end
    next_r.bus_owner = next_r.state == reb_pkg::ST_SEND;
  end

  always_ff @(posedge SYS_CLK) begin
    r <= next_r;
  end
endmodule

// ===== rtl/reb_arbiter.sv
/*
  External arbiter end of the expansion bus: grant and contention from
  the request lines of all ends.
  Assumes requests come from ends on the same SYS_CLK.
*/
`timescale 1ns/10ps
module reb_arbiter #(
  parameter int NDEV = reb_pkg::NDEV
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // status
  output logic BUS_BUSY,
  output logic CONTENTION,
  // bus
  reb_if.arb bus
);
  localparam int CW = $clog2(NDEV + 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  generate
    if (NDEV < 2) begin : g_bad
      $error("reb_arbiter: at least two ends are needed");
    end
  endgenerate

  typedef struct packed {
    logic ack_n;
    logic col_n;
    logic busy;
    logic contention;
  } reb_arb_s;

  reb_arb_s r;
  reb_arb_s next_r;
  logic [CW-1:0] active;

  assign bus.ack_n = r.ack_n;
  assign bus.col_n = r.col_n;
  assign BUS_BUSY = r.busy;
  assign CONTENTION = r.contention;

  always_comb begin
    next_r = r;
    active = '0;
    for (int i = 0; i < NDEV; i++) begin
      active = active + CW'(!bus.req_n[i]);
    end
    // grant only for exactly one request
    // grant is the one-hot term of requests
    next_r.ack_n = active != ONE;
    // contention is neither grant nor idle
    next_r.col_n = (active == ONE) || (active == '0);
    next_r.busy = active != '0;
    next_r.contention = !next_r.col_n;
    if (SYS_RST) begin
      next_r.ack_n = 1'b1;
      next_r.col_n = 1'b1;
      next_r.busy = 1'b0;
      next_r.contention = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    r <= next_r;
  end
endmodule

// ===== verif/reb_monitor.sv
/*
  Checker for the expansion bus lines: arbitration, drive and data clock.
  Assumes every end and the arbiter run on SYS_CLK.
*/
`timescale 1ns/10ps
module reb_monitor (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // shared lines
  input wire logic bus_serial_line,
  input wire logic jam_line,
  input wire logic bus_data_clock,
  input wire logic ack_n,
  input wire logic col_n,
  // per end
  input wire logic req_n [reb_pkg::NDEV],
  input wire logic bus_serial_line_oe [reb_pkg::NDEV],
  input wire logic jam_oe [reb_pkg::NDEV],
  input wire logic bus_data_clock_oe [reb_pkg::NDEV]
);
  logic [1:0] nreq;
  logic [2:0] oe_vec;
  logic [2:0] jam_vec;
  logic [2:0] clk_vec;
  always_comb begin
    nreq = 2'h0;
    for (int i = 0; i < 3; i++) begin
      nreq = nreq + 2'(!req_n[i]);
      oe_vec[i] = bus_serial_line_oe[i];
      jam_vec[i] = jam_oe[i];
      clk_vec[i] = bus_data_clock_oe[i];
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  a_grant_single: assert property ((!ack_n) == ($past(nreq) == 2'h1))
    else $error("grant does not match one request");
  a_contend_multi: assert property ((!col_n) == ($past(nreq) >= 2'h2))
    else $error("contention does not match request count");
  a_single_driver: assert property ($onehot0(oe_vec) && $onehot0(jam_vec))
    else $error("more than one end drives");
  a_contend_silent: assert property (!col_n [*8] |-> (oe_vec | jam_vec) == 3'h0)
    else $error("end drives under contention");
  a_clock_shape: assert property ($fell(bus_data_clock) && (|clk_vec)
    |-> $past(bus_data_clock, 2) && !$past(bus_data_clock, 3))
    else $error("data clock high phase wrong");
  a_async_step: assert property ((|clk_vec) && $past(|clk_vec)
    && (|oe_vec) && $past(|oe_vec)
    && !jam_line && !$past(jam_line) && $changed(bus_serial_line)
    |-> $fell(bus_data_clock))
    else $error("data changed off the clock fall");
  for (genvar i = 0; i < 3; i++) begin : gen_chk
    a_drive_granted: assert property ($rose(oe_vec[i] | jam_vec[i])
      |-> !ack_n && !req_n[i])
      else $error("line driven without grant");
    a_clock_granted: assert property ($rose(clk_vec[i]) |-> !ack_n && !req_n[i])
      else $error("data clock driven without grant");
  end
  c_grant: cover property (!ack_n);
  c_contend: cover property (!col_n);
  c_jam: cover property (jam_line);
  c_clock: cover property ($rose(bus_data_clock));
endmodule

// ===== verif/reb_tb_top.sv
/*
  Bench: three ends and the arbiter on one expansion bus interface.
  Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
`define WAIT(c) begin n = 0; while (!(c) && n < 700) begin @(negedge SYS_CLK); n++; end \
  if (n >= 700) give_up(); end
module reb_tb_top;
  logic SYS_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [2:0] strap = 3'h0, mac_n = 3'h5, act = 3'h0, coll = 3'h0, multi = 3'h0, tv = 3'h0;
  logic [7:0] td [3] = '{default: 8'h00};
  logic mode_now = 1'b0;
  wire [2:0] tready, rxv, amode, own, jact, jmul;
  wire [7:0] rxd [3];
  wire [15:0] stat [3];
  wire busy, cont;
  logic [7:0] rxq [3][$];
  int bad_count = 0;
  int check_count = 0;
  int n;
  reb_if #(.NDEV(3)) bus_if ();
  initial forever #12.5 SYS_CLK = ~SYS_CLK;
  for (genvar i = 0; i < 3; i++) begin : gen_end
    reb_device #(.SLOT(i), .NDEV(3), .FIFO_DEPTH(8)) reb_device_inst (
      .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .BUS_MODE_STRAP(strap[i]),
      .MAC_ATTACH_SELECT_N(mac_n[i]), .TX_ACTIVE(act[i]), .LOCAL_COLL(coll[i]),
      .LOCAL_MULTI(multi[i]), .TX_VALID(tv[i]), .TX_DATA(td[i]), .TX_READY(tready[i]),
      .RX_VALID(rxv[i]), .RX_DATA(rxd[i]), .ASYNC_MODE(amode[i]), .BUS_OWNER(own[i]),
      .JAM_ACTIVE(jact[i]), .JAM_MULTI(jmul[i]), .STAT_FRAMES(stat[i]), .bus(bus_if));
    // collect received bytes
    always @(negedge SYS_CLK) begin
      if (rxv[i] === 1'b1) rxq[i].push_back(rxd[i]);
    end
  end
  reb_arbiter #(.NDEV(3)) reb_arbiter_inst (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .BUS_BUSY(busy), .CONTENTION(cont), .bus(bus_if));
  reb_monitor reb_monitor_inst (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .bus_serial_line(bus_if.bus_serial_line), .jam_line(bus_if.jam_line),
    .bus_data_clock(bus_if.bus_data_clock), .ack_n(bus_if.ack_n), .col_n(bus_if.col_n),
    .req_n(bus_if.req_n), .bus_serial_line_oe(bus_if.bus_serial_line_oe),
    .jam_oe(bus_if.jam_oe), .bus_data_clock_oe(bus_if.bus_data_clock_oe));

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic give_up();
    bad_count++;
    close_out();
  endtask

  // strap flips right after release; mode must not follow it
  task automatic do_reset(input logic m);
    SYS_RST = 1'b1;
    strap = {3{m}};
    mode_now = m;
    repeat (10) @(negedge SYS_CLK);
    SYS_RST = 1'b0;
    strap = {3{~m}};
    repeat (6) @(negedge SYS_CLK);
    for (int k = 0; k < 3; k++) begin
      `CHK("async mode", m, amode[k])
      `CHK("idle drive", 1'b0, bus_if.bus_serial_line_oe[k] | bus_if.jam_oe[k])
      `CHK("idle request", 1'b1, bus_if.req_n[k])
    end
    `CHK("bus busy", 1'b0, busy)
  endtask

  // fill while stalled, then send and drain to both listeners
  task automatic t_frame();
    logic [15:0] s1;
    logic [15:0] s2;
    rxq[1].delete();
    rxq[2].delete();
    s1 = stat[1];
    s2 = stat[2];
    tv[0] = 1'b1;
    for (int k = 0; k <= 8; k++) begin
      td[0] = 8'h5a ^ 8'(k);
      @(negedge SYS_CLK);
    end
    tv[0] = 1'b0;
    `CHK("fifo refuses", 1'b0, tready[0])
    act[0] = 1'b1;
    `WAIT(own[0] === 1'b1)
    if (mode_now == 1'b0) begin
      for (int b = 0; b < 8; b++) begin
        `CHK("serial bit", 8'h5a >> b & 8'h01, 8'(bus_if.bus_serial_line))
        @(negedge SYS_CLK);
      end
    end
    `WAIT(rxq[1].size() >= 8 && rxq[2].size() >= 8)
    `CHK("clock drive", mode_now, bus_if.bus_data_clock_oe[0])
    `CHK("clk idle", 2'h0, {bus_if.bus_data_clock_oe[2], bus_if.bus_data_clock_oe[1]})
    for (int k = 0; k < 8; k++) begin
      `CHK("rx byte", 8'h5a ^ 8'(k), rxq[1][k])
      `CHK("rx byte", 8'h5a ^ 8'(k), rxq[2][k])
    end
    `CHK("frames counted", s1 + 16'h1, stat[1])
    `CHK("frames ignored", s2, stat[2])
    act[0] = 1'b0;
    `WAIT(own[0] === 1'b0)
    repeat (8) @(negedge SYS_CLK);
  endtask

  task automatic t_contend();
    act[1:0] = 2'h3;
    `WAIT(bus_if.col_n === 1'b0)
    repeat (3) @(negedge SYS_CLK);
    `CHK("contention", 1'b1, cont)
    `CHK("jam all", 3'h7, jact)
    `CHK("jam multi", 3'h7, jmul)
    act[1] = 1'b0;
    `WAIT(own[0] === 1'b1)
    `CHK("other owner", 1'b0, own[1])
    act[0] = 1'b0;
    repeat (8) @(negedge SYS_CLK);
  endtask

  task automatic t_jam();
    for (int m = 0; m < 2; m++) begin
      act[0] = 1'b1;
      `WAIT(own[0] === 1'b1)
      coll[0] = 1'b1;
      multi[0] = 1'(m);
      repeat (4) @(negedge SYS_CLK);
      `CHK("jam line", 1'b1, bus_if.jam_line)
      `CHK("jam kind", ~1'(m), bus_if.bus_serial_line)
      `CHK("follow jam", 1'b1, jact[1])
      `CHK("follow kind", 1'(m), jmul[1])
      coll[0] = 1'b0;
      act[0] = 1'b0;
      repeat (8) @(negedge SYS_CLK);
    end
  endtask

  initial begin
    do_reset(1'b0);
    t_frame();
    t_contend();
    t_jam();
    do_reset(1'b1);
    t_frame();
    close_out();
  end
endmodule
